// file: core/cfg_decode.sv
// Decoding of configuration fields into checks and effective values
`timescale 1ns/1ps
module cfg_decode (
  // Configuration words
  input wire logic [31:0] align_in,
  input wire logic [31:0] ramp_in,
  input wire logic [31:0] comm_in,
  input wire logic bidir_in,
  // Decoded results
  output logic hold_bad_out,
  output logic probe_bad_out,
  output logic ramp_bad_out,
  output logic first_bad_out,
  output logic lin_free_out,
  output logic quad_free_out,
  output logic [3:0] first_eff_out,
  output logic [4:0] down_eff_out,
  output logic [4:0] cycles_out,
  output logic csel_bad_out,
  output logic side_bad_out,
  output logic [8:0] angle_out
);
  // Past the last step the sense reference allows, a threshold is unusable
  function automatic logic curr_bad(input logic [4:0] code, input logic bidir);
    curr_bad = (code > mcfg_pkg::CURR_LAST_UNI) || (bidir && code > mcfg_pkg::CURR_LAST_BI);
  endfunction
  logic [4:0] xcyc_tab [4];
  logic [8:0] mag;
  assign xcyc_tab = '{mcfg_pkg::XCYC_0, mcfg_pkg::XCYC_1, mcfg_pkg::XCYC_2, mcfg_pkg::XCYC_3};
  assign hold_bad_out = curr_bad(align_in[mcfg_pkg::HOLD_LSB +: 5], bidir_in); // R3
  assign probe_bad_out = curr_bad(align_in[mcfg_pkg::PCURR_LSB +: 5], bidir_in); // R6
  assign ramp_bad_out = curr_bad(ramp_in[mcfg_pkg::RCURR_LSB +: 5], bidir_in); // R10
  assign first_bad_out = align_in[mcfg_pkg::FIRST_LSB +: 4] == mcfg_pkg::FIRST_UNDEF; // R8
  assign lin_free_out = ramp_in[mcfg_pkg::LIN_LSB +: 5] == mcfg_pkg::NO_LIMIT; // R11
  assign quad_free_out = ramp_in[mcfg_pkg::QUAD_LSB +: 5] == mcfg_pkg::NO_LIMIT; // R11
  // Forced zero start replaces the slow first-cycle code
  assign first_eff_out = ramp_in[mcfg_pkg::ZERO_BIT] ? 4'h0 : align_in[mcfg_pkg::FIRST_LSB +: 4]; // R14
  assign down_eff_out = comm_in[mcfg_pkg::DSRC_BIT] ? comm_in[mcfg_pkg::UP_LSB +: 5]
                                                    : comm_in[mcfg_pkg::DOWN_LSB +: 5]; // R18
  assign cycles_out = xcyc_tab[ramp_in[mcfg_pkg::XCYC_LSB +: 2]]; // R16
  assign csel_bad_out = comm_in[mcfg_pkg::CSEL_LSB +: 2] > mcfg_pkg::CSEL_LAST; // R17
  assign side_bad_out = comm_in[mcfg_pkg::SIDE_LSB +: 2] == mcfg_pkg::SIDE_BAD; // R20
  assign mag = {1'b0, comm_in[mcfg_pkg::ANG_LSB +: 8]};
  assign angle_out = comm_in[mcfg_pkg::SIGN_BIT] ? mag : 9'(-mag); // R21
endmodule

// file: core/mcfg_pkg.sv
// Offsets, field positions and codes of the start-up and closed-loop words
package mcfg_pkg;
  // ----------------------------------------
  // Word offsets and reset values
  // ----------------------------------------
  localparam logic [7:0] ALIGN_OFS = 8'h82;
  localparam logic [7:0] RAMP_OFS = 8'h84;
  localparam logic [7:0] COMM_OFS = 8'h86;
  localparam logic [7:0] STOP_OFS = 8'h88;
  localparam logic [31:0] ALIGN_RST = 32'h00000000;
  localparam logic [31:0] RAMP_RST = 32'h00000000;
  localparam logic [31:0] COMM_RST = 32'h00000000;
  localparam logic [31:0] STOP_RST = 32'h00000000;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int RATE_LSB = 27;
  localparam int TIME_LSB = 23;
  localparam int HOLD_LSB = 18;
  localparam int ADUTY_LSB = 16;
  localparam int PRATE_LSB = 13;
  localparam int PCURR_LSB = 8;
  localparam int PADV_LSB = 6;
  localparam int PAVG_LSB = 4;
  localparam int FIRST_LSB = 0;
  localparam int RDUTY_LSB = 28;
  localparam int RCURR_LSB = 23;
  localparam int LIN_LSB = 18;
  localparam int QUAD_LSB = 13;
  localparam int XSPD_LSB = 8;
  localparam int AUTO_BIT = 7;
  localparam int ZERO_BIT = 6;
  localparam int MDUTY_LSB = 2;
  localparam int XCYC_LSB = 0;
  localparam int CSEL_LSB = 29;
  localparam int UP_LSB = 24;
  localparam int DSRC_BIT = 23;
  localparam int DOWN_LSB = 18;
  localparam int SWF_LSB = 13;
  localparam int SIDE_LSB = 11;
  localparam int CMPL_BIT = 10;
  localparam int SIGN_BIT = 9;
  localparam int ANG_LSB = 1;
  // ----------------------------------------
  // Code limits and handoff cycle counts
  // ----------------------------------------
  localparam logic [4:0] CURR_LAST_UNI = 5'h1A;
  localparam logic [4:0] CURR_LAST_BI = 5'h0F;
  localparam logic [3:0] FIRST_UNDEF = 4'hA;
  localparam logic [4:0] NO_LIMIT = 5'h1F;
  localparam logic [1:0] CSEL_LAST = 2'h1;
  localparam logic [1:0] SIDE_BAD = 2'h3;
  localparam logic [4:0] XCYC_0 = 5'h03;
  localparam logic [4:0] XCYC_1 = 5'h06;
  localparam logic [4:0] XCYC_2 = 5'h0C;
  localparam logic [4:0] XCYC_3 = 5'h18;
  typedef enum logic {ST_IDLE = 1'b0, ST_ANSWER = 1'b1} step_t;
endpackage

// file: core/motor_cfg_bank.sv
// Start-up and closed-loop configuration bank behind the serial request port
// Contract
// (R1) Align voltage ramp rate is field 30-27 of the align word, codes 0-Fh.
// (R2) Align duration is field 26-23 of the align word, 5 ms to 10 s.
// (R3) Align current threshold 22-18, 0.1 V steps, high codes invalid per reference.
// (R4) Align duty limit 17-16 selects 10, 25, 50 or 100 percent.
// (R5) Position probe pulse rate is field 15-13, 50 Hz to 10 kHz.
// (R6) Position probe threshold 12-8 follows the align threshold coding.
// (R7) Probe advance angle in 7-6, probe averaging count in 5-4.
// (R8) First-turn rate is field 3-0; code Ah is undefined.
// (R9) Open-loop duty limit is field 30-28 of the ramp word.
// (R10) Open-loop current threshold 27-23 follows the shared threshold coding.
// (R11) Linear and quadratic ramp coefficients; code 1Fh means no limit.
// (R12) Loop transfer speed is field 12-8 of the ramp word.
// (R13) Bit 7 clear hands off at threshold, set chooses handoff automatically.
// (R14) Bit 6 clear uses first-turn rate, set forces 0 Hz.
// (R15) Minimum operating duty is field 5-2 of the ramp word.
// (R16) Handoff spends 3, 6, 12 or 24 cycles per field 1-0.
// (R17) Commutation select 30-29: 120 deg, variable, codes 2-3 invalid.
// (R18) Speedup and slowdown rates; bit 23 makes slowdown follow speedup.
// (R19) Output switching frequency is field 17-13 of the commutation word.
// (R20) Switch side 12-11 with code 3 invalid; bit 10 selects complementary.
// (R21) Angle offset is bits 8-1 times 0.12 deg, lag or lead by bit 9.
// (R22) Controller sets bit 31 as word parity and writes reserved bits zero.
// (R23) Serial requests reach the words; two wait, a third is refused.
`timescale 1ns/1ps
module motor_cfg_bank #(
  parameter int QUEUE_DEPTH = 2
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic ce_in,
  // Core status
  input wire logic busy_in,
  input wire logic sense_bidir_in,
  // Serial request port
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic [7:0] req_addr_in,
  input wire logic [31:0] req_wdata_in,
  output logic req_ready_out,
  output logic rsp_valid_out,
  output logic rsp_err_out,
  output logic [31:0] rsp_rdata_out,
  // Align and position detection
  output logic [3:0] align_ramp_rate_out,
  output logic [3:0] align_time_out,
  output logic [4:0] hold_current_limit_out,
  output logic hold_limit_bad_out,
  output logic [1:0] align_duty_out,
  output logic [2:0] position_probe_rate_out,
  output logic [4:0] position_probe_current_out,
  output logic probe_current_bad_out,
  output logic [1:0] position_probe_advance_out,
  output logic [1:0] position_probe_averaging_out,
  output logic [3:0] first_turn_rate_out,
  output logic first_turn_bad_out,
  // Open-loop ramp and handoff
  output logic [2:0] ramp_duty_limit_out,
  output logic [4:0] ramp_current_limit_out,
  output logic ramp_current_bad_out,
  output logic [4:0] ramp_linear_coeff_out,
  output logic [4:0] ramp_quadratic_coeff_out,
  output logic linear_unlimited_out,
  output logic quadratic_unlimited_out,
  output logic [4:0] loop_transfer_speed_out,
  output logic auto_handoff_out,
  output logic first_turn_zero_out,
  output logic [3:0] first_turn_eff_out,
  output logic [3:0] min_duty_out,
  output logic [1:0] transfer_cycle_count_out,
  output logic [4:0] transfer_cycles_out,
  // Closed loop
  output logic [1:0] commutation_angle_sel_out,
  output logic commutation_bad_out,
  output logic [4:0] loop_speedup_rate_out,
  output logic [4:0] loop_slowdown_rate_out,
  output logic slowdown_source_sel_out,
  output logic [4:0] loop_slowdown_eff_out,
  output logic [4:0] switch_freq_sel_out,
  output logic [1:0] switch_side_sel_out,
  output logic switch_side_bad_out,
  output logic complementary_out,
  output logic angle_offset_sign_out,
  output logic [7:0] angle_offset_value_out,
  output logic [8:0] angle_offset_signed_out,
  output logic [31:0] stop_limit_config_out
);
  if (QUEUE_DEPTH < 1)
  begin : g_chk
    $error("queue depth must be at least one");
  end
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    mcfg_pkg::step_t step;
    logic [31:0] align_w;
    logic [31:0] ramp_w;
    logic [31:0] comm_w;
    logic [31:0] stop_w;
    logic rsp_valid;
    logic rsp_err;
    logic [31:0] rsp_data;
    logic hold_bad;
    logic probe_bad;
    logic ramp_bad;
    logic first_bad;
    logic lin_free;
    logic quad_free;
    logic [3:0] first_eff;
    logic [4:0] down_eff;
    logic [4:0] cycles;
    logic csel_bad;
    logic side_bad;
    logic [8:0] angle;
  } bank_state_t;
  bank_state_t st_r;
  bank_state_t st_nxt;
  // Decodes the offset once for both reads and writes
  function automatic logic [3:0] word_hit(input logic [7:0] addr);
    word_hit = {addr == mcfg_pkg::STOP_OFS, addr == mcfg_pkg::COMM_OFS,
                addr == mcfg_pkg::RAMP_OFS, addr == mcfg_pkg::ALIGN_OFS};
  endfunction
  // ----------------------------------------
  // Request queue and field decode
  // ----------------------------------------
  logic q_valid;
  logic q_pop;
  logic [40:0] q_data;
  logic q_wr;
  logic [7:0] q_addr;
  logic [31:0] q_wdata;
  logic [3:0] hit;
  logic d_hold;
  logic d_probe;
  logic d_ramp;
  logic d_first;
  logic d_lin;
  logic d_quad;
  logic [3:0] d_feff;
  logic [4:0] d_down;
  logic [4:0] d_cyc;
  logic d_csel;
  logic d_side;
  logic [8:0] d_angle;
  // Work waits while the core is busy; the queue soaks up the backlog
  req_queue #(.WIDTH(41), .DEPTH(QUEUE_DEPTH)) u_queue (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .ce_in(ce_in),
    .push_in(req_valid_in),
    .data_in({req_write_in, req_addr_in, req_wdata_in}),
    .ready_out(req_ready_out),
    .pop_in(q_pop),
    .valid_out(q_valid),
    .data_out(q_data)
  ); // R23
  assign {q_wr, q_addr, q_wdata} = q_data;
  assign hit = word_hit(q_addr);
  assign q_pop = q_valid && !busy_in && (st_r.step == mcfg_pkg::ST_IDLE); // R23
  // Flags trail a stored word by one cycle
  cfg_decode u_decode (
    .align_in(st_r.align_w),
    .ramp_in(st_r.ramp_w),
    .comm_in(st_r.comm_w),
    .bidir_in(sense_bidir_in),
    .hold_bad_out(d_hold),
    .probe_bad_out(d_probe),
    .ramp_bad_out(d_ramp),
    .first_bad_out(d_first),
    .lin_free_out(d_lin),
    .quad_free_out(d_quad),
    .first_eff_out(d_feff),
    .down_eff_out(d_down),
    .cycles_out(d_cyc),
    .csel_bad_out(d_csel),
    .side_bad_out(d_side),
    .angle_out(d_angle)
  );
  // ----------------------------------------
  // Request handling
  // ----------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.rsp_valid = 1'b0;
    unique case (st_r.step)
      mcfg_pkg::ST_IDLE:
      begin
        if (q_pop)
        begin
          st_nxt.rsp_valid = 1'b1;
          st_nxt.rsp_err = hit == 4'h0; // R23
          st_nxt.rsp_data = 32'h00000000;
          st_nxt.step = mcfg_pkg::ST_ANSWER;
          if (q_wr)
          begin
            if (hit[0])
              st_nxt.align_w = q_wdata; // R1 R2 R4 R5 R7
            if (hit[1])
              st_nxt.ramp_w = q_wdata; // R9 R12 R13 R15
            if (hit[2])
              st_nxt.comm_w = q_wdata; // R19 R20
            if (hit[3])
              st_nxt.stop_w = q_wdata;
          end
          else
          begin
            unique case (1'b1)
              hit[0]: st_nxt.rsp_data = st_r.align_w;
              hit[1]: st_nxt.rsp_data = st_r.ramp_w;
              hit[2]: st_nxt.rsp_data = st_r.comm_w;
              hit[3]: st_nxt.rsp_data = st_r.stop_w;
              default: st_nxt.rsp_data = 32'h00000000;
            endcase
          end
        end
      end
      mcfg_pkg::ST_ANSWER:
      begin
        st_nxt.step = mcfg_pkg::ST_IDLE;
      end
    endcase
    st_nxt.hold_bad = d_hold; // R3
    st_nxt.probe_bad = d_probe; // R6
    st_nxt.ramp_bad = d_ramp; // R10
    st_nxt.first_bad = d_first; // R8
    st_nxt.lin_free = d_lin; // R11
    st_nxt.quad_free = d_quad;
    st_nxt.first_eff = d_feff; // R14
    st_nxt.down_eff = d_down; // R18
    st_nxt.cycles = d_cyc; // R16
    st_nxt.csel_bad = d_csel; // R17
    st_nxt.side_bad = d_side;
    st_nxt.angle = d_angle; // R21
  end
  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      st_r <= '0;
      st_r.align_w <= mcfg_pkg::ALIGN_RST;
      st_r.ramp_w <= mcfg_pkg::RAMP_RST;
      st_r.comm_w <= mcfg_pkg::COMM_RST;
      st_r.stop_w <= mcfg_pkg::STOP_RST;
    end
    else if (ce_in)
      st_r <= st_nxt;
  end
  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign rsp_valid_out = st_r.rsp_valid;
  assign rsp_err_out = st_r.rsp_err;
  assign rsp_rdata_out = st_r.rsp_data;
  assign align_ramp_rate_out = st_r.align_w[mcfg_pkg::RATE_LSB +: 4]; // R1
  assign align_time_out = st_r.align_w[mcfg_pkg::TIME_LSB +: 4]; // R2
  assign hold_current_limit_out = st_r.align_w[mcfg_pkg::HOLD_LSB +: 5]; // R3
  assign hold_limit_bad_out = st_r.hold_bad;
  assign align_duty_out = st_r.align_w[mcfg_pkg::ADUTY_LSB +: 2]; // R4
  assign position_probe_rate_out = st_r.align_w[mcfg_pkg::PRATE_LSB +: 3]; // R5
  assign position_probe_current_out = st_r.align_w[mcfg_pkg::PCURR_LSB +: 5]; // R6
  assign probe_current_bad_out = st_r.probe_bad;
  assign position_probe_advance_out = st_r.align_w[mcfg_pkg::PADV_LSB +: 2]; // R7
  assign position_probe_averaging_out = st_r.align_w[mcfg_pkg::PAVG_LSB +: 2]; // R7
  assign first_turn_rate_out = st_r.align_w[mcfg_pkg::FIRST_LSB +: 4]; // R8
  assign first_turn_bad_out = st_r.first_bad;
  assign ramp_duty_limit_out = st_r.ramp_w[mcfg_pkg::RDUTY_LSB +: 3]; // R9
  assign ramp_current_limit_out = st_r.ramp_w[mcfg_pkg::RCURR_LSB +: 5]; // R10
  assign ramp_current_bad_out = st_r.ramp_bad;
  assign ramp_linear_coeff_out = st_r.ramp_w[mcfg_pkg::LIN_LSB +: 5]; // R11
  assign ramp_quadratic_coeff_out = st_r.ramp_w[mcfg_pkg::QUAD_LSB +: 5]; // R11
  assign linear_unlimited_out = st_r.lin_free;
  assign quadratic_unlimited_out = st_r.quad_free;
  assign loop_transfer_speed_out = st_r.ramp_w[mcfg_pkg::XSPD_LSB +: 5]; // R12
  assign auto_handoff_out = st_r.ramp_w[mcfg_pkg::AUTO_BIT]; // R13
  assign first_turn_zero_out = st_r.ramp_w[mcfg_pkg::ZERO_BIT]; // R14
  assign first_turn_eff_out = st_r.first_eff;
  assign min_duty_out = st_r.ramp_w[mcfg_pkg::MDUTY_LSB +: 4]; // R15
  assign transfer_cycle_count_out = st_r.ramp_w[mcfg_pkg::XCYC_LSB +: 2]; // R16
  assign transfer_cycles_out = st_r.cycles;
  assign commutation_angle_sel_out = st_r.comm_w[mcfg_pkg::CSEL_LSB +: 2]; // R17
  assign commutation_bad_out = st_r.csel_bad;
  assign loop_speedup_rate_out = st_r.comm_w[mcfg_pkg::UP_LSB +: 5]; // R18
  assign loop_slowdown_rate_out = st_r.comm_w[mcfg_pkg::DOWN_LSB +: 5]; // R18
  assign slowdown_source_sel_out = st_r.comm_w[mcfg_pkg::DSRC_BIT]; // R18
  assign loop_slowdown_eff_out = st_r.down_eff;
  assign switch_freq_sel_out = st_r.comm_w[mcfg_pkg::SWF_LSB +: 5]; // R19
  assign switch_side_sel_out = st_r.comm_w[mcfg_pkg::SIDE_LSB +: 2]; // R20
  assign switch_side_bad_out = st_r.side_bad;
  assign complementary_out = st_r.comm_w[mcfg_pkg::CMPL_BIT]; // R20
  assign angle_offset_sign_out = st_r.comm_w[mcfg_pkg::SIGN_BIT]; // R21
  assign angle_offset_value_out = st_r.comm_w[mcfg_pkg::ANG_LSB +: 8]; // R21
  assign angle_offset_signed_out = st_r.angle;
  assign stop_limit_config_out = st_r.stop_w;
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  sequence take_s;
    ce_in && q_pop;
  endsequence
  sequence answer_s;
    rsp_valid_out ##1 !rsp_valid_out;
  endsequence
  queue_refuse_a: assert property (q_valid && $past(ce_in) && !req_ready_out |-> busy_in || $past(busy_in) || !$past(q_pop)) // R23
    else $error("full queue state inconsistent");
  answer_pulse_a: assert property (take_s |=> answer_s) // R23
    else $error("answer did not follow a taken request");
  unmapped_err_a: assert property (take_s and (hit == 4'h0) |=> rsp_err_out) // R23
    else $error("unmapped offset not flagged");
  align_store_a: assert property (take_s and q_wr and hit[0] |=> st_r.align_w == $past(q_wdata)) // R1
    else $error("align word not stored");
  hold_check_a: assert property ($past(ce_in) |-> hold_limit_bad_out == ($past(hold_current_limit_out) > 5'h1A
    || ($past(sense_bidir_in) && $past(hold_current_limit_out) > 5'h0F))) // R3
    else $error("align threshold check wrong");
  slowdown_src_a: assert property ($past(ce_in) |-> loop_slowdown_eff_out == ($past(slowdown_source_sel_out)
    ? $past(loop_speedup_rate_out) : $past(loop_slowdown_rate_out))) // R18
    else $error("slowdown source wrong");
  first_zero_a: assert property ($past(ce_in) && $past(first_turn_zero_out) |-> first_turn_eff_out == 4'h0) // R14
    else $error("forced zero first turn not applied");
  cycles_map_a: assert property ($past(ce_in) && $past(transfer_cycle_count_out) == 2'h3
    |-> transfer_cycles_out == 5'h18) // R16
    else $error("handoff cycle count wrong");
  comm_bad_a: assert property ($past(ce_in) |-> commutation_bad_out == ($past(commutation_angle_sel_out) > 2'h1)) // R17
    else $error("commutation code check wrong");
  angle_sign_a: assert property ($past(ce_in) && !$past(angle_offset_sign_out) |->
    angle_offset_signed_out == 9'(-{1'b0, $past(angle_offset_value_out)})) // R21
    else $error("lag offset sign wrong");
endmodule

// file: core/req_queue.sv
// Request queue holding pending register requests
`timescale 1ns/1ps
module req_queue #(
  parameter int WIDTH = 41,
  parameter int DEPTH = 2
) (
  // Clock
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic ce_in,
  // Fill side
  input wire logic push_in,
  input wire logic [WIDTH-1:0] data_in,
  output logic ready_out,
  // Drain side
  input wire logic pop_in,
  output logic valid_out,
  output logic [WIDTH-1:0] data_out
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  if (DEPTH < 1 || WIDTH < 1)
  begin : g_chk
    $error("queue depth and width must be positive");
  end
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [CW-1:0] count;
    logic ready;
  } q_state_t;
  q_state_t st_r;
  q_state_t st_nxt;
  logic push_ok;
  logic pop_ok;
  always_comb
  begin
    st_nxt = st_r;
    push_ok = push_in && st_r.ready;
    pop_ok = pop_in && (st_r.count != '0);
    if (push_ok)
    begin
      st_nxt.mem[st_r.wr] = data_in;
      st_nxt.wr = (st_r.wr == PW'(DEPTH - 1)) ? '0 : st_r.wr + 1'b1;
    end
    if (pop_ok)
      st_nxt.rd = (st_r.rd == PW'(DEPTH - 1)) ? '0 : st_r.rd + 1'b1;
    if (push_ok && !pop_ok)
      st_nxt.count = st_r.count + 1'b1;
    else if (pop_ok && !push_ok)
      st_nxt.count = st_r.count - 1'b1;
    // A full queue refuses the next request until one drains
    st_nxt.ready = st_nxt.count != CW'(DEPTH);
  end
  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
      st_r <= '{mem: '0, wr: '0, rd: '0, count: '0, ready: 1'b1};
    else if (ce_in)
      st_r <= st_nxt;
  end
  assign ready_out = st_r.ready;
  assign valid_out = st_r.count != '0;
  assign data_out = st_r.mem[st_r.rd];
endmodule

// file: dv/mcu_model.sv
// External controller model driving the word request port
`timescale 1ns/1ps
module mcu_model (
  // Clock and flow control
  input wire logic clk_in,
  input wire logic req_ready_in,
  // Request side
  output logic req_valid_out,
  output logic req_write_out,
  output logic [7:0] req_addr_out,
  output logic [31:0] req_wdata_out
);
  // ----------------------------------------
  // Request issue
  // ----------------------------------------
  initial
  begin
    req_valid_out = 1'b0;
    req_write_out = 1'b0;
    req_addr_out = 8'h00;
    req_wdata_out = 32'h00000000;
  end
  // Gives up after lim edges, so a refused request cannot hang the caller
  task automatic send(input logic wr, input logic [7:0] a, input logic [30:0] d, input int lim);
    int n;
    begin
      n = 0;
      @(posedge clk_in);
      req_valid_out <= 1'b1;
      req_write_out <= wr;
      req_addr_out <= a;
      req_wdata_out <= {^d, d};
      @(posedge clk_in);
      while (req_ready_in !== 1'b1 && n < lim)
      begin
        n++;
        @(posedge clk_in);
      end
      req_valid_out <= 1'b0;
      // Released data must not look like the last word
      req_wdata_out <= ~{^d, d};
    end
  endtask
endmodule

// file: dv/tb_top.sv
// Self-checking bench for the configuration bank
`timescale 1ns/1ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin n_errors++; $display("unexpected %s exp %h got %h", n, e, s); end end
module tb_top;
  logic clk_in = 1'b0;
  logic reset_n_in, ce_in, busy_in, bidir, req_valid, req_write, req_ready, rsp_valid, rsp_err;
  logic [7:0] req_addr;
  logic [31:0] req_wdata, rsp_rdata;
  logic [30:0] av, rv;
  logic [4:0] cyc_tab [4] = '{5'h03, 5'h06, 5'h0C, 5'h18};
  int n_errors = 0;
  int cmp_count = 0;
  int n_rsp = 0;
  int base;
  // ----------------------------------------
  // Instances and helpers
  // ----------------------------------------
  mcu_model mcu_u (.clk_in(clk_in), .req_ready_in(req_ready), .req_valid_out(req_valid), .req_write_out(req_write),
    .req_addr_out(req_addr), .req_wdata_out(req_wdata));
  motor_cfg_bank dut_u (.clk_in(clk_in), .reset_n_in(reset_n_in), .ce_in(ce_in), .busy_in(busy_in),
    .sense_bidir_in(bidir), .req_valid_in(req_valid), .req_write_in(req_write), .req_addr_in(req_addr),
    .req_wdata_in(req_wdata), .req_ready_out(req_ready), .rsp_valid_out(rsp_valid), .rsp_err_out(rsp_err),
    .rsp_rdata_out(rsp_rdata), .align_ramp_rate_out(), .align_time_out(), .hold_current_limit_out(),
    .hold_limit_bad_out(), .align_duty_out(), .position_probe_rate_out(), .position_probe_current_out(),
    .probe_current_bad_out(), .position_probe_advance_out(), .position_probe_averaging_out(),
    .first_turn_rate_out(), .first_turn_bad_out(), .ramp_duty_limit_out(), .ramp_current_limit_out(),
    .ramp_current_bad_out(), .ramp_linear_coeff_out(), .ramp_quadratic_coeff_out(), .linear_unlimited_out(),
    .quadratic_unlimited_out(), .loop_transfer_speed_out(), .auto_handoff_out(), .first_turn_zero_out(),
    .first_turn_eff_out(), .min_duty_out(), .transfer_cycle_count_out(), .transfer_cycles_out(),
    .commutation_angle_sel_out(), .commutation_bad_out(), .loop_speedup_rate_out(), .loop_slowdown_rate_out(),
    .slowdown_source_sel_out(), .loop_slowdown_eff_out(), .switch_freq_sel_out(), .switch_side_sel_out(),
    .switch_side_bad_out(), .complementary_out(), .angle_offset_sign_out(), .angle_offset_value_out(),
    .angle_offset_signed_out(), .stop_limit_config_out());
  initial
  forever #4 clk_in = ~clk_in;
  always @(posedge clk_in)
    if (rsp_valid === 1'b1) n_rsp++;
  function automatic logic [31:0] w(input logic [30:0] d);
    return {^d, d};
  endfunction
  task automatic wait_rsp(input logic err);
    int n;
    begin
      n = 0;
      while (rsp_valid !== 1'b1 && n < 20)
      begin
        n++;
        @(posedge clk_in);
      end
      `CHK("latency", 2, n)
      `CHK("rsp_err", err, rsp_err)
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [30:0] d);
    begin
      mcu_u.send(1'b1, a, d, 20);
      wait_rsp(1'b0);
      repeat (3) @(posedge clk_in);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err);
    begin
      mcu_u.send(1'b0, a, 31'h0, 20);
      wait_rsp(err);
      `CHK("rsp_rdata", e, rsp_rdata)
    end
  endtask
  task automatic cl(input logic [30:0] v, input logic [15:0] e);
    begin
      wr(8'h86, v);
      `CHK("comm", v[30:1], {dut_u.commutation_angle_sel_out, dut_u.loop_speedup_rate_out, dut_u.slowdown_source_sel_out, dut_u.loop_slowdown_rate_out, dut_u.switch_freq_sel_out, dut_u.switch_side_sel_out, dut_u.complementary_out, dut_u.angle_offset_sign_out, dut_u.angle_offset_value_out})
      `CHK("comm_dec", e, {dut_u.commutation_bad_out, dut_u.switch_side_bad_out, dut_u.loop_slowdown_eff_out, dut_u.angle_offset_signed_out})
    end
  endtask
  task automatic final_report;
    begin
      $display("compares %0d errors %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    reset_n_in = 1'b0;
    ce_in = 1'b1;
    busy_in = 1'b0;
    bidir = 1'b0;
    repeat (16) @(posedge clk_in);
    reset_n_in <= 1'b1;
    for (int i = 0; i < 4; i++) rd(8'h82 + 8'(2 * i), 32'h00000000, 1'b0);
    `CHK("cycles_rst", 5'h03, dut_u.transfer_cycles_out)
    rd(8'h8A, 32'h00000000, 1'b1);
    av = {4'h9, 4'h3, 5'h1B, 2'h2, 3'h5, 5'h10, 2'h3, 2'h1, 4'hA};
    wr(8'h82, av);
    `CHK("align", av, {dut_u.align_ramp_rate_out, dut_u.align_time_out, dut_u.hold_current_limit_out, dut_u.align_duty_out, dut_u.position_probe_rate_out, dut_u.position_probe_current_out, dut_u.position_probe_advance_out, dut_u.position_probe_averaging_out, dut_u.first_turn_rate_out})
    `CHK("align_dec", 3'b101, {dut_u.hold_limit_bad_out, dut_u.probe_current_bad_out, dut_u.first_turn_bad_out})
    bidir <= 1'b1;
    repeat (3) @(posedge clk_in);
    `CHK("probe_bad", 1'b1, dut_u.probe_current_bad_out)
    rd(8'h82, w(av), 1'b0);
    rv = {3'h7, 5'h0F, 5'h1F, 5'h1E, 5'h15, 1'b1, 1'b1, 4'hF, 2'h0};
    for (int i = 0; i < 4; i++)
    begin
      rv[1:0] = 2'(i);
      wr(8'h84, rv);
      `CHK("cycles", cyc_tab[i], dut_u.transfer_cycles_out)
    end
    `CHK("ramp", rv, {dut_u.ramp_duty_limit_out, dut_u.ramp_current_limit_out, dut_u.ramp_linear_coeff_out, dut_u.ramp_quadratic_coeff_out, dut_u.loop_transfer_speed_out, dut_u.auto_handoff_out, dut_u.first_turn_zero_out, dut_u.min_duty_out, dut_u.transfer_cycle_count_out})
    `CHK("ramp_dec", 7'h20, {dut_u.ramp_current_bad_out, dut_u.linear_unlimited_out, dut_u.quadratic_unlimited_out, dut_u.first_turn_eff_out})
    rv[6] = 1'b0;
    rv[17:13] = 5'h1F;
    wr(8'h84, rv);
    `CHK("first_eff", 4'hA, dut_u.first_turn_eff_out)
    `CHK("quad_free", 2'b11, {dut_u.linear_unlimited_out, dut_u.quadratic_unlimited_out})
    cl({2'h2, 5'h11, 1'b1, 5'h04, 5'h1F, 2'h3, 1'b1, 1'b0, 8'h05, 1'b0}, {1'b1, 1'b1, 5'h11, 9'h1FB});
    cl({2'h1, 5'h11, 1'b0, 5'h04, 5'h00, 2'h2, 1'b0, 1'b1, 8'hFF, 1'b0}, {1'b0, 1'b0, 5'h04, 9'h0FF});
    base = n_rsp;
    busy_in <= 1'b1;
    mcu_u.send(1'b1, 8'h88, 31'h12345678, 20);
    mcu_u.send(1'b0, 8'h88, 31'h0, 20);
    @(posedge clk_in);
    `CHK("ready_full", 1'b0, req_ready)
    mcu_u.send(1'b1, 8'h88, 31'h000000FF, 3);
    busy_in <= 1'b0;
    repeat (20) @(posedge clk_in);
    `CHK("answers", base + 2, n_rsp)
    `CHK("stop", w(31'h12345678), dut_u.stop_limit_config_out)
    `CHK("read_last", w(31'h12345678), rsp_rdata)
    base = n_rsp;
    ce_in <= 1'b0;
    mcu_u.send(1'b1, 8'h88, 31'h0, 3);
    ce_in <= 1'b1;
    repeat (10) @(posedge clk_in);
    `CHK("frozen", base, n_rsp)
    final_report;
  end
  initial
  begin
    repeat (5000) @(posedge clk_in);
    n_errors++;
    final_report;
  end
endmodule
